// file: hw/modem_ctl_pkg.sv
// register map, field positions and reset values for the modem control block
package modem_ctl_pkg;
	// byte addresses on the register bus
	localparam logic [7:0] ADDR_MODEM_LINE_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_ENHANCED_FEATURE = 8'h04;
	localparam logic [7:0] ADDR_PIN_FUNCTION = 8'h08;
	localparam logic [7:0] ADDR_PIN_LEVEL_STATE = 8'h0C;
	localparam logic [7:0] ADDR_MODEM_LINE_STATUS = 8'h10;
	localparam logic [7:0] ADDR_FLOW_CONFIG = 8'h14;
	// modem_line_control fields
	localparam int MLC_PRESCALE = 7;
	localparam int MLC_INFRARED = 6;
	localparam int MLC_ANY_RESUME = 5;
	localparam int MLC_LOOPBACK = 4;
	localparam int MLC_RESERVED = 3;
	localparam int MLC_TRIG_ACCESS = 2;
	localparam int MLC_RTS = 1;
	localparam int MLC_DTR = 0;
	// bits that need the enhanced write enable
	localparam logic [7:0] MLC_PROTECTED_MASK = 8'hE4;
	localparam logic [7:0] MLC_WRITE_MASK = 8'hF7;
	// enhanced_feature_reg write-enable bit
	localparam int EFR_ENHANCED = 4;
	// pin_function_control: modem pins selected
	localparam int PFC_MODEM_PINS = 1;
	// pin_level_state: bit that drives general_pin_five
	localparam int PLS_PIN_FIVE = 5;
	// flow config: automatic rts enable
	localparam int FLOW_AUTO_RTS = 0;
	// modem_line_status cts bit
	localparam int MLS_CTS = 4;
	localparam int MLS_DSR = 5;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h00000000;
	localparam logic [1:0] PRESCALE_DIV = 2'h3;
endpackage

// file: hw/modem_line_control.sv
// modem line control register with apb slave, loopback and modem pin drive
`timescale 1ns/100ps
module modem_line_control (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// uart datapath
	input wire logic tx_serial,
	input wire logic rx_pin,
	output logic rx_serial,
	input wire logic auto_rts_level_n,
	output logic baud_tick,
	output logic infrared_mode,
	output logic any_resume_en,
	output logic trig_regs_en,
	// modem pins
	input wire logic cts_n_pin,
	input wire logic dsr_n_pin,
	output logic rts_n,
	output logic general_pin_five,
	output logic general_pin_five_oe
);
	logic [7:0] mlc_q;
	logic [7:0] efr_q;
	logic [7:0] pin_func_q;
	logic [7:0] pin_state_q;
	logic [7:0] flow_q;
	logic [1:0] cts_sync_q;
	logic [1:0] dsr_sync_q;
	logic [1:0] rx_sync_q;
	logic [1:0] presc_q;
	logic baud_tick_q;
	logic rts_n_q;
	logic pin_five_q;
	logic pin_five_oe_q;
	logic rx_serial_q;
	logic [7:0] status;
	logic wr_access;
	logic rd_access;
	logic addr_known;

	function automatic logic is_mapped(input logic [7:0] a);
		return a == modem_ctl_pkg::ADDR_MODEM_LINE_CONTROL ||
			a == modem_ctl_pkg::ADDR_ENHANCED_FEATURE ||
			a == modem_ctl_pkg::ADDR_PIN_FUNCTION ||
			a == modem_ctl_pkg::ADDR_PIN_LEVEL_STATE ||
			a == modem_ctl_pkg::ADDR_MODEM_LINE_STATUS ||
			a == modem_ctl_pkg::ADDR_FLOW_CONFIG;
	endfunction

	// single-cycle access phase keeps the master simple
	assign pready = 1'b1;
	assign addr_known = is_mapped(paddr);
	assign pslverr = psel && penable && !addr_known;
	assign wr_access = psel && penable && pwrite && addr_known;
	assign rd_access = psel && penable && !pwrite && addr_known;

	// pins are asynchronous to core_clk
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cts_sync_q <= 2'h3;
			dsr_sync_q <= 2'h3;
			rx_sync_q <= 2'h3;
		end else begin
			cts_sync_q <= {cts_sync_q[0], cts_n_pin};
			dsr_sync_q <= {dsr_sync_q[0], dsr_n_pin};
			rx_sync_q <= {rx_sync_q[0], rx_pin};
		end
	end

	// modem line control register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mlc_q <= modem_ctl_pkg::RESET_BYTE;
		end else if (wr_access &&
			paddr == modem_ctl_pkg::ADDR_MODEM_LINE_CONTROL) begin
			if (efr_q[modem_ctl_pkg::EFR_ENHANCED]) begin
				mlc_q <= pwdata[7:0] & modem_ctl_pkg::MLC_WRITE_MASK;
			end else begin
				mlc_q <= (mlc_q & modem_ctl_pkg::MLC_PROTECTED_MASK) |
					(pwdata[7:0] & modem_ctl_pkg::MLC_WRITE_MASK &
					~modem_ctl_pkg::MLC_PROTECTED_MASK);
			end
		end
	end

	// supporting registers that steer this block
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			efr_q <= modem_ctl_pkg::RESET_BYTE;
			pin_func_q <= modem_ctl_pkg::RESET_BYTE;
			pin_state_q <= modem_ctl_pkg::RESET_BYTE;
			flow_q <= modem_ctl_pkg::RESET_BYTE;
		end else if (wr_access) begin
			case (paddr)
				modem_ctl_pkg::ADDR_ENHANCED_FEATURE: begin
					efr_q <= pwdata[7:0];
				end
				modem_ctl_pkg::ADDR_PIN_FUNCTION: begin
					pin_func_q <= pwdata[7:0];
				end
				modem_ctl_pkg::ADDR_PIN_LEVEL_STATE: begin
					pin_state_q <= pwdata[7:0];
				end
				modem_ctl_pkg::ADDR_FLOW_CONFIG: begin
					flow_q <= pwdata[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// modem status view
	always_comb begin
		status = modem_ctl_pkg::RESET_BYTE;
		if (mlc_q[modem_ctl_pkg::MLC_LOOPBACK]) begin
			status[modem_ctl_pkg::MLS_CTS] = mlc_q[modem_ctl_pkg::MLC_RTS];
			status[modem_ctl_pkg::MLS_DSR] = mlc_q[modem_ctl_pkg::MLC_DTR];
		end else begin
			status[modem_ctl_pkg::MLS_CTS] = ~cts_sync_q[1];
			status[modem_ctl_pkg::MLS_DSR] = ~dsr_sync_q[1];
		end
	end

	// read data registered on the setup edge (psel high, penable low), ready in the access phase
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			prdata <= modem_ctl_pkg::READ_ZERO;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				modem_ctl_pkg::ADDR_MODEM_LINE_CONTROL: begin
					prdata <= {24'h000000, mlc_q};
				end
				modem_ctl_pkg::ADDR_ENHANCED_FEATURE: begin
					prdata <= {24'h000000, efr_q};
				end
				modem_ctl_pkg::ADDR_PIN_FUNCTION: begin
					prdata <= {24'h000000, pin_func_q};
				end
				modem_ctl_pkg::ADDR_PIN_LEVEL_STATE: begin
					prdata <= {24'h000000, pin_state_q};
				end
				modem_ctl_pkg::ADDR_MODEM_LINE_STATUS: begin
					prdata <= {24'h000000, status};
				end
				modem_ctl_pkg::ADDR_FLOW_CONFIG: begin
					prdata <= {24'h000000, flow_q};
				end
				default: begin
					prdata <= modem_ctl_pkg::READ_ZERO;
				end
			endcase
		end
	end

	// baud prescaler: tick every cycle, or one in four
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			presc_q <= 2'h0;
			baud_tick_q <= 1'b0;
		end else begin
			if (mlc_q[modem_ctl_pkg::MLC_PRESCALE]) begin
				presc_q <= presc_q + 2'h1;
				baud_tick_q <= (presc_q == modem_ctl_pkg::PRESCALE_DIV);
			end else begin
				presc_q <= 2'h0;
				baud_tick_q <= 1'b1;
			end
		end
	end

	// receive input mux
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rx_serial_q <= 1'b1;
		end else if (mlc_q[modem_ctl_pkg::MLC_LOOPBACK]) begin
			rx_serial_q <= tx_serial;
		end else begin
			rx_serial_q <= rx_sync_q[1];
		end
	end

	// modem outputs; loopback holds rts_n inactive, and general_pin_five too when modem pins are selected
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rts_n_q <= 1'b1;
		end else if (mlc_q[modem_ctl_pkg::MLC_LOOPBACK]) begin
			rts_n_q <= 1'b1;
		end else if (flow_q[modem_ctl_pkg::FLOW_AUTO_RTS]) begin
			rts_n_q <= auto_rts_level_n;
		end else begin
			rts_n_q <= ~mlc_q[modem_ctl_pkg::MLC_RTS];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pin_five_q <= 1'b1;
			pin_five_oe_q <= 1'b0;
		end else if (pin_func_q[modem_ctl_pkg::PFC_MODEM_PINS]) begin
			pin_five_oe_q <= 1'b1;
			pin_five_q <= mlc_q[modem_ctl_pkg::MLC_LOOPBACK] ||
				~mlc_q[modem_ctl_pkg::MLC_DTR];
		end else begin
			pin_five_oe_q <= 1'b1;
			pin_five_q <= pin_state_q[modem_ctl_pkg::PLS_PIN_FIVE];
		end
	end

	assign rx_serial = rx_serial_q;
	assign baud_tick = baud_tick_q;
	assign rts_n = rts_n_q;
	assign general_pin_five = pin_five_q;
	assign general_pin_five_oe = pin_five_oe_q;
	assign infrared_mode = mlc_q[modem_ctl_pkg::MLC_INFRARED];
	assign any_resume_en = mlc_q[modem_ctl_pkg::MLC_ANY_RESUME];
	assign trig_regs_en = mlc_q[modem_ctl_pkg::MLC_TRIG_ACCESS];
endmodule

// file: testbench/modem_line_control_props.sv
// property checker for the modem line control block
`timescale 1ns/100ps
module modem_line_control_props (
	input wire logic core_clk, nrst, psel, penable, pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready, pslverr, baud_tick, infrared_mode,
	input wire logic any_resume_en, trig_regs_en, rts_n,
	input wire logic auto_rts_level_n, rx_serial
);
	localparam logic [7:0] A = modem_ctl_pkg::ADDR_MODEM_LINE_CONTROL;
	logic w_any;
	logic w_ctl;
	assign w_any = psel && penable && pwrite;
	assign w_ctl = w_any && paddr == A;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// after a tick falls, the next one comes within three idle cycles
	sequence tick_soon;
		!baud_tick ##[0:3] baud_tick;
	endsequence
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_bad_addr: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
		else $error("no error on unmapped address");
	chk_tick_gap: assert property ($fell(baud_tick) |-> tick_soon)
		else $error("baud tick gap too long");
	chk_ir_set: assert property ($rose(infrared_mode) |-> $past(w_ctl && pwdata[6]))
		else $error("infrared mode set without write");
	chk_resume_clear: assert property ($fell(any_resume_en) |-> $past(w_ctl && !pwdata[5]))
		else $error("resume enable cleared without write");
	chk_trig_set: assert property ($rose(trig_regs_en) |-> $past(w_ctl && pwdata[2]))
		else $error("trigger access set without write");
	chk_rts_cause: assert property ($changed(rts_n) |-> $past(w_any, 2) ||
		$past(auto_rts_level_n) != $past(auto_rts_level_n, 2))
		else $error("rts moved with no cause");
	chk_release_idle: assert property ($rose(nrst) |-> rts_n && !baud_tick && rx_serial)
		else $error("outputs not idle after reset");
endmodule
bind modem_line_control modem_line_control_props i_props (.core_clk, .nrst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .baud_tick,
	.infrared_mode, .any_resume_en, .trig_regs_en, .rts_n, .auto_rts_level_n,
	.rx_serial);

// file: testbench/modem_peer.sv
// modem side model: echoes the host's handshake lines after a lag
`timescale 1ns/100ps
module modem_peer #(parameter int LAG = 3) (
	input wire logic core_clk,
	input wire logic rts_n,
	input wire logic dtr_n,
	output logic cts_n,
	output logic dsr_n,
	output logic rx_pin
);
	logic [LAG-1:0] rts_d = '1;
	logic [LAG-1:0] dtr_d = '1;
	// a slow modem: cts_n and dsr_n answer LAG cycles after the host moves a line; rx_pin follows rts_n after one cycle
	always @(posedge core_clk) begin
		rts_d <= {rts_d[LAG-2:0], rts_n};
		dtr_d <= {dtr_d[LAG-2:0], dtr_n};
	end
	assign cts_n = rts_d[LAG-1];
	assign dsr_n = dtr_d[LAG-1];
	assign rx_pin = rts_d[0];
endmodule

// file: testbench/uart_modem_control_register_bench.sv
// self-checking bench for the modem line control register
`timescale 1ns/100ps
module uart_modem_control_register_bench;
	localparam logic [7:0] A_CTL = modem_ctl_pkg::ADDR_MODEM_LINE_CONTROL;
	localparam logic [7:0] A_EFR = modem_ctl_pkg::ADDR_ENHANCED_FEATURE;
	localparam logic [7:0] A_PFC = modem_ctl_pkg::ADDR_PIN_FUNCTION;
	localparam logic [7:0] A_PLS = modem_ctl_pkg::ADDR_PIN_LEVEL_STATE;
	localparam logic [7:0] A_STS = modem_ctl_pkg::ADDR_MODEM_LINE_STATUS;
	localparam logic [7:0] A_FLW = modem_ctl_pkg::ADDR_FLOW_CONFIG;
	logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic tx_serial = 1, auto_rts_level_n = 1, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, r;
	logic pready, pslverr, rx_pin, rx_serial, baud_tick, infrared_mode;
	logic any_resume_en, trig_regs_en, cts_n_pin, dsr_n_pin, rts_n;
	logic general_pin_five, general_pin_five_oe;
	int fails = 0, num_checks = 0, seed = 29;
	int ctl = 0, enhanced_feature_reg = 0, pfc = 0, pls = 0, flw = 0, ticks;
	modem_line_control i_dut (.core_clk, .nrst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .tx_serial, .rx_pin,
		.rx_serial, .auto_rts_level_n, .baud_tick, .infrared_mode,
		.any_resume_en, .trig_regs_en, .cts_n_pin, .dsr_n_pin, .rts_n,
		.general_pin_five, .general_pin_five_oe);
	modem_peer #(.LAG(3)) i_peer (.core_clk, .rts_n, .dtr_n(general_pin_five),
		.cts_n(cts_n_pin), .dsr_n(dsr_n_pin), .rx_pin);
	initial forever #50 core_clk = ~core_clk;
	task automatic test_done;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic ck(input string s, input logic [31:0] x, g);
		num_checks++;
		if (g !== x) begin
			fails++;
			$display("BAD %s exp %h got %h", s, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge core_clk);
		end
		if (n >= 50)
			fails++;
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		// protected bits keep their value unless the enhanced enable is set
		if (w && a == A_CTL)
			ctl = enhanced_feature_reg[4] ? d & 'hF7 : (ctl & 'hE4) | (d & 'h13);
		if (w && a == A_EFR)
			enhanced_feature_reg = d[7:0];
		if (w && a == A_PFC)
			pfc = d[7:0];
		if (w && a == A_PLS)
			pls = d[7:0];
		if (w && a == A_FLW)
			flw = d[7:0];
		@(posedge core_clk);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		nrst <= 1;
		@(posedge core_clk);
		apb(0, A_CTL, 0);
		ck("ctl reset", 0, r);
		apb(0, 8'h40, 0);
		ck("unmapped err", 1, e);
		ck("unmapped data", 0, r);
		for (int i = 0; i < 24; i++) begin
			apb(1, A_EFR, $random(seed));
			apb(1, A_PFC, $random(seed));
			apb(1, A_PLS, $random(seed));
			apb(1, A_FLW, $random(seed));
			apb(1, A_CTL, $random(seed));
			tx_serial <= $random(seed);
			auto_rts_level_n <= $random(seed);
			repeat (8) @(posedge core_clk);
			ticks = 0;
			repeat (8) begin
				@(posedge core_clk);
				ticks += baud_tick;
			end
			ck("ticks", ctl[7] ? 2 : 8, ticks);
			ck("infrared", ctl[6], infrared_mode);
			ck("resume", ctl[5], any_resume_en);
			ck("rx", ctl[4] ? tx_serial : rx_pin, rx_serial);
			ck("trig", ctl[2], trig_regs_en);
			ck("rts", ctl[4] ? 1 : flw[0] ? auto_rts_level_n : !ctl[1], rts_n);
			ck("pin5", pfc[1] ? ctl[4] | !ctl[0] : pls[5], general_pin_five);
			ck("pin5 oe", 1, general_pin_five_oe);
			apb(0, A_CTL, 0);
			ck("ctl", ctl, r);
			apb(0, A_STS, 0);
			ck("status", ctl[4] ? {ctl[0], ctl[1]} : {!dsr_n_pin, !cts_n_pin}, r[5:4]);
		end
		test_done;
	end
	initial begin
		#500000;
		fails++;
		test_done;
	end
endmodule
